// *** rtl/posd_cfg.svh ***
`ifndef POSD_CFG_SVH
`define POSD_CFG_SVH

// register byte offsets
`define POSD_OFS_CTRL     8'h00
`define POSD_OFS_STATUS   8'h04
`define POSD_OFS_STRAP    8'h08
`define POSD_OFS_CLOCKS   8'h0c
`define POSD_OFS_MISC     8'h10

// control register reset value and field position
`define POSD_CTRL_RESET   1'b1
`define POSD_CTRL_DRV_BIT 0

// timing
`define POSD_CLK_PERIOD_NS 100
`define POSD_SETTLE_NS     1000
`define POSD_SETTLE_CYC    ((`POSD_SETTLE_NS + `POSD_CLK_PERIOD_NS - 1) / `POSD_CLK_PERIOD_NS)
`define POSD_RST_HOLD_NS   100000
`define POSD_RST_HOLD_CYC  (`POSD_RST_HOLD_NS / `POSD_CLK_PERIOD_NS)

// decoded defaults
`define POSD_MEM_MHZ_RESET 11'h0a6

`endif

// *** rtl/posd_pkg.sv ***
package posd_pkg;

  typedef enum logic [1:0] {
    POSD_SYM_LOW   = 2'b00,
    POSD_SYM_HIGH  = 2'b01,
    POSD_SYM_FLOAT = 2'b10
  } posd_sym_t;

  typedef enum logic [2:0] {
    POSD_ST_HOLD     = 3'b000,
    POSD_ST_PULL_UP  = 3'b001,
    POSD_ST_PULL_DN  = 3'b010,
    POSD_ST_DECODE   = 3'b011,
    POSD_ST_RST_HOLD = 3'b100,
    POSD_ST_RUN      = 3'b101
  } posd_state_t;

  typedef enum logic [1:0] {
    POSD_PHY_INTERNAL = 2'b00,
    POSD_PHY_EXTERNAL = 2'b01,
    POSD_PHY_AFE_TEST = 2'b10
  } posd_phy_t;

endpackage : posd_pkg

// *** rtl/posd_top.sv ***
`timescale 1ns/1ps
`include "posd_cfg.svh"
module posd_top
  import posd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // board
  input  wire logic        power_good_in_i,
  input  wire logic        phy_select_strap_i,
  output logic             sys_reset_o,
  output logic             strap_pull_up_o,
  output logic             strap_pull_dn_o,
  // memory address pads
  input  wire logic [14:0] mem_addr_req_i,
  input  wire logic [14:0] mem_addr_in_i,
  output logic      [14:0] mem_addr_o,
  output logic      [14:0] mem_addr_oe_o,
  // decoded settings
  output logic      [1:0]  phy_mode_o,
  output logic             gpio_port_two_en_o,
  output logic             upper_addr_en_o,
  output logic             pll_test_out_en_o,
  output logic      [10:0] mem_clk_mhz_o,
  output logic      [10:0] cpu_clk_mhz_o,
  output logic             cpu_bypass_o,
  output logic             cpu_clock_tied_to_memory_o,
  output logic             cpu_code_invalid_o
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic posd_sym_t resolve(input logic up, input logic dn);
    if (up && dn) begin
      resolve = POSD_SYM_HIGH;
    end else if (!up && !dn) begin
      resolve = POSD_SYM_LOW;
    end else begin
      resolve = POSD_SYM_FLOAT;
    end
  endfunction : resolve

  function automatic logic [10:0] mem_mhz(input logic [3:0] code);
    case (code)
      {POSD_SYM_LOW,   POSD_SYM_HIGH}:  mem_mhz = 11'd166;
      {POSD_SYM_HIGH,  POSD_SYM_FLOAT}: mem_mhz = 11'd200;
      {POSD_SYM_HIGH,  POSD_SYM_LOW}:   mem_mhz = 11'd233;
      {POSD_SYM_LOW,   POSD_SYM_LOW}:   mem_mhz = 11'd266;
      {POSD_SYM_LOW,   POSD_SYM_FLOAT}: mem_mhz = 11'd300;
      {POSD_SYM_FLOAT, POSD_SYM_HIGH}:  mem_mhz = 11'd333;
      {POSD_SYM_FLOAT, POSD_SYM_LOW}:   mem_mhz = 11'd366;
      {POSD_SYM_FLOAT, POSD_SYM_FLOAT}: mem_mhz = 11'd400;
      default:                          mem_mhz = 11'd0;
    endcase
  endfunction : mem_mhz

  // returns {invalid, tied, bypass, mhz}
  function automatic logic [13:0] cpu_sel(input logic [5:0] code);
    localparam logic [1:0] L = POSD_SYM_LOW;
    localparam logic [1:0] H = POSD_SYM_HIGH;
    localparam logic [1:0] Z = POSD_SYM_FLOAT;
    case (code)
      {H, L, L}: cpu_sel = {3'b001, 11'd0};
      {H, L, H}: cpu_sel = {3'b010, 11'd0};
      {H, H, Z}: cpu_sel = {3'b000, 11'd500};
      {H, H, L}: cpu_sel = {3'b000, 11'd600};
      {H, H, H}: cpu_sel = {3'b000, 11'd700};
      {Z, Z, Z}: cpu_sel = {3'b000, 11'd800};
      {Z, Z, L}: cpu_sel = {3'b000, 11'd900};
      {Z, Z, H}: cpu_sel = {3'b000, 11'd933};
      {Z, L, L}: cpu_sel = {3'b000, 11'd1000};
      {Z, L, H}: cpu_sel = {3'b000, 11'd1033};
      {Z, H, Z}: cpu_sel = {3'b000, 11'd1066};
      {Z, H, L}: cpu_sel = {3'b000, 11'd1066};
      {Z, H, H}: cpu_sel = {3'b000, 11'd1066};
      {L, Z, Z}: cpu_sel = {3'b000, 11'd1100};
      {L, Z, L}: cpu_sel = {3'b000, 11'd1133};
      {L, Z, H}: cpu_sel = {3'b000, 11'd1166};
      default:   cpu_sel = {3'b100, 11'd0};
    endcase
  endfunction : cpu_sel

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [1:0] pg_sync_ff;
  logic [7:0] strap_meta_ff;
  logic [7:0] strap_sync_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pg_sync_ff    <= 2'h0;
      strap_meta_ff <= 8'h00;
      strap_sync_ff <= 8'h00;
    end else begin
      pg_sync_ff    <= {pg_sync_ff[0], power_good_in_i};
      strap_meta_ff <= {mem_addr_in_i[10], mem_addr_in_i[7:3], mem_addr_in_i[1],
                        phy_select_strap_i};
      strap_sync_ff <= strap_meta_ff;
    end
  end

  wire logic power_good = pg_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // reset and strap sequence

  posd_state_t state_ff;
  posd_state_t nxt_state;
  logic [9:0]  cnt_ff;
  logic [7:0]  up_ff;
  logic [7:0]  dn_ff;
  logic        cfg_valid_ff;

  wire logic settle_done = (cnt_ff == 10'(`POSD_SETTLE_CYC - 1));
  wire logic hold_done   = (cnt_ff == 10'(`POSD_RST_HOLD_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      POSD_ST_HOLD:     nxt_state = POSD_ST_PULL_UP;
      POSD_ST_PULL_UP:  if (settle_done) nxt_state = POSD_ST_PULL_DN;
      POSD_ST_PULL_DN:  if (settle_done) nxt_state = POSD_ST_DECODE;
      POSD_ST_DECODE:   nxt_state = POSD_ST_RST_HOLD;
      POSD_ST_RST_HOLD: if (hold_done) nxt_state = POSD_ST_RUN;
      POSD_ST_RUN:      nxt_state = POSD_ST_RUN;
      default:          nxt_state = POSD_ST_HOLD;
    endcase
    if (!power_good) begin
      nxt_state = POSD_ST_HOLD;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= POSD_ST_HOLD;
      cnt_ff   <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? 10'h000 : cnt_ff + 10'h001;
    end
  end

  // two pulled samples tell a driven pin from a floating one
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      up_ff <= 8'h00;
      dn_ff <= 8'h00;
    end else begin
      if (state_ff == POSD_ST_PULL_UP && settle_done) up_ff <= strap_sync_ff;
      if (state_ff == POSD_ST_PULL_DN && settle_done) dn_ff <= strap_sync_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode

  posd_sym_t  sym [8];
  for (genvar i = 0; i < 8; i++) begin : g_sym
    assign sym[i] = resolve(up_ff[i], dn_ff[i]);
  end

  wire logic [15:0] sym_vec = {sym[7], sym[6], sym[5], sym[4], sym[3], sym[2], sym[1], sym[0]};
  wire logic [10:0] mem_sel = mem_mhz({sym[7], sym[3]});
  wire logic [13:0] cpu_dec = cpu_sel({sym[6], sym[5], sym[4]});
  wire logic        decode  = (state_ff == POSD_ST_DECODE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phy_mode_o                 <= POSD_PHY_AFE_TEST;
      gpio_port_two_en_o         <= 1'b1;
      upper_addr_en_o            <= 1'b0;
      pll_test_out_en_o          <= 1'b0;
      mem_clk_mhz_o              <= `POSD_MEM_MHZ_RESET;
      cpu_clk_mhz_o              <= 11'h000;
      cpu_bypass_o               <= 1'b1;
      cpu_clock_tied_to_memory_o <= 1'b0;
      cpu_code_invalid_o         <= 1'b0;
      cfg_valid_ff               <= 1'b0;
    end else if (decode) begin
      phy_mode_o                 <= sym[0];
      gpio_port_two_en_o         <= (sym[1] != POSD_SYM_LOW);
      upper_addr_en_o            <= (sym[1] == POSD_SYM_LOW);
      pll_test_out_en_o          <= (sym[2] == POSD_SYM_HIGH);
      mem_clk_mhz_o              <= mem_sel;
      cpu_clk_mhz_o              <= cpu_dec[12] ? mem_sel : cpu_dec[10:0];
      cpu_bypass_o               <= cpu_dec[11];
      cpu_clock_tied_to_memory_o <= cpu_dec[12];
      cpu_code_invalid_o         <= cpu_dec[13];
      cfg_valid_ff               <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pads and system reset

  logic ctrl_drv_ff;

  wire logic run = (nxt_state == POSD_ST_RUN);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o     <= 1'b1;
      strap_pull_up_o <= 1'b0;
      strap_pull_dn_o <= 1'b0;
      mem_addr_o      <= 15'h0000;
      mem_addr_oe_o   <= 15'h0000;
    end else begin
      sys_reset_o     <= !run;
      strap_pull_up_o <= (nxt_state == POSD_ST_PULL_UP);
      strap_pull_dn_o <= (nxt_state == POSD_ST_PULL_DN);
      mem_addr_o      <= mem_addr_req_i;
      mem_addr_oe_o   <= {15{run && ctrl_drv_ff}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic       dwr_ff;
  logic [7:0] daddr_ff;

  wire logic       take   = hsel_i && hready_i && htrans_i[1];
  wire logic [7:0] ofs    = {haddr_i[7:2], 2'b00};
  wire logic [31:0] rd_mux =
    (ofs == `POSD_OFS_CTRL)   ? {31'h0, ctrl_drv_ff} :
    (ofs == `POSD_OFS_STATUS) ? {27'h0, cfg_valid_ff, sys_reset_o, state_ff} :
    (ofs == `POSD_OFS_STRAP)  ? {16'h0, sym_vec} :
    (ofs == `POSD_OFS_CLOCKS) ? {2'h0, cpu_code_invalid_o, cpu_clock_tied_to_memory_o,
                                cpu_bypass_o, cpu_clk_mhz_o, 5'h00, mem_clk_mhz_o} :
    (ofs == `POSD_OFS_MISC)   ? {27'h0, pll_test_out_en_o, upper_addr_en_o,
                                gpio_port_two_en_o, phy_mode_o} :
    32'h0;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dwr_ff      <= 1'b0;
      daddr_ff    <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      ctrl_drv_ff <= `POSD_CTRL_RESET;
    end else begin
      dwr_ff      <= take && hwrite_i;
      daddr_ff    <= ofs;
      hrdata_o    <= (take && !hwrite_i) ? rd_mux : 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (dwr_ff && daddr_ff == `POSD_OFS_CTRL) begin
        ctrl_drv_ff <= hwdata_i[`POSD_CTRL_DRV_BIT];
      end
    end
  end

endmodule : posd_top

// *** verification/posd_board.sv ***
`timescale 1ns/1ps
module posd_board
  import posd_pkg::*;
(
  // clock
  input  wire logic        clk_sys_i,
  // pulls and pad drive from the device
  input  wire logic        pull_up_i,
  input  wire logic        pull_dn_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [14:0] oe_i,
  // strap fitting, index 15 is the phy strap
  input  posd_sym_t        sym_i [16],
  // pad levels
  output logic      [14:0] pad_o,
  output logic             phy_o
);
  logic        tgl_ff = 1'b0;
  logic [15:0] lvl;

  // an undriven open pad wanders
  always @(posedge clk_sys_i) tgl_ff <= ~tgl_ff;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      case (sym_i[i])
        POSD_SYM_LOW:  lvl[i] = 1'b0;
        POSD_SYM_HIGH: lvl[i] = 1'b1;
        default:       lvl[i] = pull_up_i ? 1'b1 : (pull_dn_i ? 1'b0 : tgl_ff);
      endcase
      if (i < 15 && oe_i[i[3:0]]) lvl[i] = addr_i[i[3:0]];
    end
  end

  assign pad_o = lvl[14:0];
  assign phy_o = lvl[15];
endmodule : posd_board

// *** verification/posd_checker.sv ***
`timescale 1ns/1ps
module posd_checker (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // board and pads
  input wire logic        power_good_in_i,
  input wire logic        sys_reset_o,
  input wire logic        strap_pull_up_o,
  input wire logic        strap_pull_dn_o,
  input wire logic [14:0] mem_addr_req_i,
  input wire logic [14:0] mem_addr_o,
  input wire logic [14:0] mem_addr_oe_o,
  // decoded settings
  input wire logic [1:0]  phy_mode_o,
  input wire logic        gpio_port_two_en_o,
  input wire logic        upper_addr_en_o,
  input wire logic [10:0] mem_clk_mhz_o,
  input wire logic [10:0] cpu_clk_mhz_o,
  input wire logic        cpu_bypass_o,
  input wire logic        cpu_clock_tied_to_memory_o,
  input wire logic        cpu_code_invalid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_oe_in_reset: assert property (sys_reset_o |-> mem_addr_oe_o == 15'h0)
    else $error("address pads driven in reset");
  a_addr_follow: assert property (!$past(rst_i) |-> mem_addr_o == $past(mem_addr_req_i))
    else $error("address pads do not follow request");
  a_port_excl: assert property (gpio_port_two_en_o != upper_addr_en_o)
    else $error("port two and upper address disagree");
  a_cfg_hold: assert property (!sys_reset_o |=> $stable({phy_mode_o, gpio_port_two_en_o,
    mem_clk_mhz_o, cpu_clk_mhz_o, upper_addr_en_o, cpu_bypass_o, cpu_code_invalid_o}))
    else $error("settings changed while running");
  a_bypass_clk: assert property (cpu_bypass_o |-> cpu_clk_mhz_o == 11'h0)
    else $error("bypass with cpu clock");
  a_tied_clk: assert property (cpu_clock_tied_to_memory_o |->
    cpu_clk_mhz_o == mem_clk_mhz_o)
    else $error("tied cpu clock differs");
  a_invalid_clk: assert property (cpu_code_invalid_o |-> cpu_clk_mhz_o == 11'h0)
    else $error("invalid code with cpu clock");
  a_pulls_excl: assert property (!(strap_pull_up_o && strap_pull_dn_o))
    else $error("both pulls on");
  a_pg_reset: assert property (!power_good_in_i [*4] |-> sys_reset_o)
    else $error("no reset without power good");
  a_pull_len: assert property (disable iff (rst_i || !power_good_in_i)
    $rose(strap_pull_up_o) |-> ##9 strap_pull_up_o ##1 strap_pull_dn_o)
    else $error("pull phase length wrong");

  cover property ($fell(sys_reset_o));
  cover property (cpu_code_invalid_o && !sys_reset_o);
  cover property (cpu_clock_tied_to_memory_o && !sys_reset_o);
endmodule : posd_checker

bind posd_top posd_checker chk_u (.*);

// *** verification/posd_tb_top.sv ***
`timescale 1ns/1ps
module posd_tb_top import posd_pkg::*;;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, power_good_in_i = 1'b0;
  logic        hsel_i = 1'b0, hwrite_i = 1'b0, hready_i, hreadyout_o, hresp_o;
  logic        phy_select_strap_i, sys_reset_o, strap_pull_up_o, strap_pull_dn_o;
  logic        gpio_port_two_en_o, upper_addr_en_o, pll_test_out_en_o, cpu_bypass_o;
  logic        cpu_clock_tied_to_memory_o, cpu_code_invalid_o;
  logic [1:0]  htrans_i = 2'h0, phy_mode_o;
  logic [2:0]  hsize_i = 3'h2;
  logic [7:0]  haddr_i = 8'h00;
  logic [31:0] hwdata_i = 32'h0, hrdata_o;
  logic [14:0] mem_addr_req_i = 15'h0, mem_addr_in_i, mem_addr_o, mem_addr_oe_o;
  logic [10:0] mem_clk_mhz_o, cpu_clk_mhz_o;
  posd_sym_t   sym [16];
  int          fails = 0, samples_checked = 0;
  // cpu table by base-3 code (0 low, 1 high, 2 float); -1 bypass, -2 tied
  int cpu_t [27] = '{0, 0, 0, 0, 0, 0, 1133, 1166, 1100, -1, -2, 0, 600, 700, 500, 0, 0, 0,
                     1000, 1033, 0, 1066, 1066, 1066, 900, 933, 800};
  int mem_t [9] = '{266, 166, 300, 233, 0, 200, 366, 333, 400};

  assign hready_i = hreadyout_o;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) mem_addr_req_i <= 15'($urandom);

  posd_top dut_u (.*);
  posd_board board_u (
    .clk_sys_i (clk_sys_i),
    .pull_up_i (strap_pull_up_o),
    .pull_dn_i (strap_pull_dn_o),
    .addr_i    (mem_addr_o),
    .oe_i      (mem_addr_oe_o),
    .sym_i     (sym),
    .pad_o     (mem_addr_in_i),
    .phy_o     (phy_select_strap_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 32'(hresp_o), 32'h0);
  endtask : ahb

  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int d [16];
    int k, m, cv, n;
    logic [31:0] rd, e;
    void'($urandom(87));
    foreach (sym[i]) sym[i] = POSD_SYM_FLOAT;
    repeat (4) @(posedge clk_sys_i);
    rd = {cpu_bypass_o, pll_test_out_en_o, upper_addr_en_o, gpio_port_two_en_o,
          phy_mode_o, sys_reset_o, mem_clk_mhz_o};
    chk("rst_def", rd, {1'h1, 1'h0, 1'h0, 1'h1, 2'h2, 1'h1, 11'h0a6});
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (k = 0; k < 27; k++) begin
      power_good_in_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      m = k % 9;
      foreach (d[i]) d[i] = $urandom % 3;
      d[7] = k / 9;
      d[6] = (k / 3) % 3;
      d[5] = k % 3;
      d[10] = m / 3;
      d[4] = m % 3;
      foreach (d[i]) sym[i] <= posd_sym_t'(2'(d[i]));
      power_good_in_i <= 1'b1;
      if (k == 13) begin
        // abort in mid sampling
        repeat (8) @(posedge clk_sys_i);
        power_good_in_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        power_good_in_i <= 1'b1;
      end
      n = 0;
      while (sys_reset_o !== 1'b0 && n < 1200) begin
        @(posedge clk_sys_i);
        n++;
      end
      chk("run_hold", {sys_reset_o, n > 1000}, 32'h1);
      chk("oe_run", 32'(mem_addr_oe_o), 32'h7fff);
      cv = cpu_t[k];
      e = {2'h0, cv == 0, cv == -2, cv == -1,
           11'(cv > 0 ? cv : (cv == -2 ? mem_t[m] : 0)), 5'h0, 11'(mem_t[m])};
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk("clocks_reg", rd, e);
      rd = {2'h0, cpu_code_invalid_o, cpu_clock_tied_to_memory_o, cpu_bypass_o,
            cpu_clk_mhz_o, 5'h0, mem_clk_mhz_o};
      chk("clocks_pin", rd, e);
      e = {27'h0, d[3] == 1, d[1] == 0, d[1] != 0, 2'(d[15])};
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk("misc_reg", rd, e);
      rd = {27'h0, pll_test_out_en_o, upper_addr_en_o, gpio_port_two_en_o, phy_mode_o};
      chk("misc_pin", rd, e);
      e = {16'h0, 2'(d[10]), 2'(d[7]), 2'(d[6]), 2'(d[5]), 2'(d[4]), 2'(d[3]), 2'(d[1]),
           2'(d[15])};
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("strap_reg", rd, e);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("status_reg", rd, {27'h0, 1'b1, 1'b0, POSD_ST_RUN});
    end
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl_rst", rd, 32'h1);
    ahb(1'b1, 8'h00, 32'h0, rd);
    repeat (2) @(posedge clk_sys_i);
    chk("oe_off", 32'(mem_addr_oe_o), 32'h0);
    ahb(1'b0, 8'h14, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fails++;
    end_sim();
  end
endmodule : posd_tb_top
